// [src/adc_scan_and_pin_config.sv]
// Scan-select masks, pin-mode masks and per-converter input steering.
// Assumes a plain register port on mclk and done pulses from the
// conversion sequencer on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "adc_scan_params.svh"

module adc_scan_and_pin_config (
  input  wire logic                   mclk,
  input  wire logic                   rst,
  input  wire logic [`ADDR_W-1:0]     addr,
  input  wire logic [`DATA_W-1:0]     wdata,
  input  wire logic                   wr,
  input  wire logic                   rd,
  output logic      [`DATA_W-1:0]     rdata_q,
  input  wire logic                   conv1_done,
  input  wire logic                   conv2_done,
  output adc_scan_pkg::mux_sel_t      conv1_sel_q,
  output adc_scan_pkg::mux_sel_t      conv2_sel_q,
  output logic      [`NUM_INPUTS-1:0] pin_digital_q,
  output logic      [`NUM_INPUTS-1:0] port_read_en_q
);

  ////////////////////////////////////////////////////////////////////////
  // Software-visible registers
  logic [`DATA_W-1:0] scan1_lo_q, scan1_lo_d;
  logic [`DATA_W-1:0] scan1_hi_q, scan1_hi_d;
  logic [`DATA_W-1:0] scan2_lo_q, scan2_lo_d;
  logic [`DATA_W-1:0] scan2_hi_q, scan2_hi_d;
  logic [`DATA_W-1:0] mode1_lo_q, mode1_lo_d;
  logic [`DATA_W-1:0] mode1_hi_q, mode1_hi_d;
  logic [`DATA_W-1:0] mode2_lo_q, mode2_lo_d;
  logic [`CTRL_W-1:0] ctrl_q,     ctrl_d;

  // Derived masks
  logic [`NUM_INPUTS-1:0] scan1_mask;
  logic [`NUM_LOW-1:0]    scan2_mask;
  logic [`NUM_INPUTS-1:0] mode1_mask;
  logic [`NUM_INPUTS-1:0] mode2_mask;
  logic [`NUM_INPUTS-1:0] present;
  logic [`NUM_INPUTS-1:0] digital_d;

  // Walker state
  logic [`CHAN_W-1:0]     w1_chan;
  logic                   w1_active;
  logic                   w1_wrap;
  logic [`LOW_CHAN_W-1:0] w2_chan;
  logic                   w2_active;
  logic                   w2_wrap;

  adc_scan_pkg::mux_sel_t conv1_sel_d;
  adc_scan_pkg::mux_sel_t conv2_sel_d;
  logic [`DATA_W-1:0]     rdata_d;
  logic [`DATA_W-1:0]     status;

  ////////////////////////////////////////////////////////////////////////
  // Register writes: every bit stored whatever the package bonds out
  always_comb begin
    scan1_lo_d = scan1_lo_q;
    scan1_hi_d = scan1_hi_q;
    scan2_lo_d = scan2_lo_q;
    scan2_hi_d = scan2_hi_q;
    mode1_lo_d = mode1_lo_q;
    mode1_hi_d = mode1_hi_q;
    mode2_lo_d = mode2_lo_q;
    ctrl_d     = ctrl_q;
    if (wr) begin
      case (addr)
        `OFS_SCAN1_LO: begin
          scan1_lo_d = wdata;
        end
        `OFS_SCAN1_HI: begin
          scan1_hi_d = wdata;
        end
        `OFS_SCAN2_LO: begin
          scan2_lo_d = wdata;
        end
        `OFS_SCAN2_HI: begin
          scan2_hi_d = wdata;
        end
        `OFS_MODE1_LO: begin
          mode1_lo_d = wdata;
        end
        `OFS_MODE1_HI: begin
          mode1_hi_d = wdata;
        end
        `OFS_MODE2_LO: begin
          mode2_lo_d = wdata;
        end
        `OFS_CTRL: begin
          ctrl_d = wdata[`CTRL_W-1:0];
        end
        default: begin
          ctrl_d = ctrl_q;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      scan1_lo_q <= `REG_RESET;
      scan1_hi_q <= `REG_RESET;
      scan2_lo_q <= `REG_RESET;
      scan2_hi_q <= `REG_RESET;
      mode1_lo_q <= `REG_RESET;
      mode1_hi_q <= `REG_RESET;
      mode2_lo_q <= `REG_RESET;
      ctrl_q     <= '0;
    end else begin
      scan1_lo_q <= scan1_lo_d;
      scan1_hi_q <= scan1_hi_d;
      scan2_lo_q <= scan2_lo_d;
      scan2_hi_q <= scan2_hi_d;
      mode1_lo_q <= mode1_lo_d;
      mode1_hi_q <= mode1_hi_d;
      mode2_lo_q <= mode2_lo_d;
      ctrl_q     <= ctrl_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mask assembly
  always_comb begin
    present    = `PRESENT_MASK;
    scan1_mask = {scan1_hi_q, scan1_lo_q};
    // Upper selections of the second converter are stored but never
    // reach its walker, which only spans the shared low inputs.
    scan2_mask = scan2_lo_q;
    mode1_mask = {mode1_hi_q, mode1_lo_q};
    // No upper mode register exists for the second converter
    mode2_mask = {{`NUM_LOW{1'b0}}, mode2_lo_q};
  end

  // A shared low pin turns digital if either converter asks for it;
  // absent inputs have no pin, so their bits change nothing.
  always_comb begin
    digital_d = (mode1_mask | mode2_mask) & present;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      pin_digital_q  <= `PINS_RESET;
      port_read_en_q <= `PINS_RESET;
    end else begin
      pin_digital_q  <= digital_d;
      port_read_en_q <= digital_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Scan walkers
  scan_walker #(
    .N  (`NUM_INPUTS),
    .CW (`CHAN_W)
  ) walk1 (
    .mclk     (mclk),
    .rst      (rst),
    .enable   (ctrl_q[`CTRL_EN1_BIT]),
    .advance  (conv1_done),
    .mask     (scan1_mask),
    .chan_q   (w1_chan),
    .active_q (w1_active),
    .wrap_q   (w1_wrap)
  );

  scan_walker #(
    .N  (`NUM_LOW),
    .CW (`LOW_CHAN_W)
  ) walk2 (
    .mclk     (mclk),
    .rst      (rst),
    .enable   (ctrl_q[`CTRL_EN2_BIT]),
    .advance  (conv2_done),
    .mask     (scan2_mask),
    .chan_q   (w2_chan),
    .active_q (w2_active),
    .wrap_q   (w2_wrap)
  );

  ////////////////////////////////////////////////////////////////////////
  // Multiplexer steering: absent input converts the low reference,
  // an input whose mode bit for that converter is set sees analog ground instead of its pin.
  always_comb begin
    conv1_sel_d         = '0;
    conv1_sel_d.active  = w1_active;
    conv1_sel_d.chan    = w1_chan;
    conv1_sel_d.wrap    = w1_wrap;
    conv1_sel_d.low_ref = w1_active && !present[w1_chan];
    conv1_sel_d.ground  = w1_active && present[w1_chan]
                          && mode1_mask[w1_chan];
  end

  always_comb begin
    conv2_sel_d         = '0;
    conv2_sel_d.active  = w2_active;
    conv2_sel_d.chan    = {1'b0, w2_chan};
    conv2_sel_d.wrap    = w2_wrap;
    conv2_sel_d.low_ref = w2_active
                          && !present[{1'b0, w2_chan}];
    conv2_sel_d.ground  = w2_active && present[{1'b0, w2_chan}]
                          && mode2_mask[{1'b0, w2_chan}];
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      conv1_sel_q <= '0;
      conv2_sel_q <= '0;
    end else begin
      conv1_sel_q <= conv1_sel_d;
      conv2_sel_q <= conv2_sel_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path: data one cycle after the strobe, zero when idle
  always_comb begin
    status = '0;
    status[`STS_CH1_LSB +: `CHAN_W]     = w1_chan;
    status[`STS_ACT1_BIT]               = w1_active;
    status[`STS_CH2_LSB +: `LOW_CHAN_W] = w2_chan;
    status[`STS_ACT2_BIT]               = w2_active;
  end

  always_comb begin
    rdata_d = '0;
    if (rd) begin
      case (addr)
        `OFS_SCAN1_LO: begin
          rdata_d = scan1_lo_q;
        end
        `OFS_SCAN1_HI: begin
          rdata_d = scan1_hi_q;
        end
        `OFS_SCAN2_LO: begin
          rdata_d = scan2_lo_q;
        end
        `OFS_SCAN2_HI: begin
          rdata_d = scan2_hi_q;
        end
        `OFS_MODE1_LO: begin
          rdata_d = mode1_lo_q;
        end
        `OFS_MODE1_HI: begin
          rdata_d = mode1_hi_q;
        end
        `OFS_MODE2_LO: begin
          rdata_d = mode2_lo_q;
        end
        `OFS_CTRL: begin
          rdata_d = {{(`DATA_W-`CTRL_W){1'b0}}, ctrl_q};
        end
        `OFS_EFF_LO: begin
          rdata_d = pin_digital_q[`NUM_LOW-1:0];
        end
        `OFS_EFF_HI: begin
          rdata_d = pin_digital_q[`NUM_INPUTS-1:`NUM_LOW];
        end
        `OFS_STATUS: begin
          rdata_d = status;
        end
        default: begin
          rdata_d = '0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

endmodule

`default_nettype wire

// [src/adc_scan_params.svh]
// Constants of the scan-select and pin-mode register block.
// Assumes inclusion by bare name from the package and design files.
// Contract
// - Set scan bit includes input; clear skips
// - High scan register bit n is input n+16
// - Low scan register bit n is input n
// - All scan bits writable; absent input converts reference
// - Mode bit one: digital, read enabled, ground
// - Mode bit zero: analog, read disabled, sample
// - Mode bits always read/write; absent inputs ignored
// - High mode register only on first converter
// - High mode bit n maps input n+16
// - Both low mode registers affect shared pins
// - All bits reset to zero, pins analog
// - Scan registers are full sixteen-bit read/write
// - Second converter scans only inputs 0 to 15
`ifndef ADC_SCAN_PARAMS_SVH
`define ADC_SCAN_PARAMS_SVH

`define ADDR_W        4
`define DATA_W        16
`define NUM_INPUTS    32
`define NUM_LOW       16
`define CHAN_W        5
`define LOW_CHAN_W    4

// Register indices on the plain register port
`define OFS_SCAN1_LO  4'h0
`define OFS_SCAN1_HI  4'h1
`define OFS_SCAN2_LO  4'h2
`define OFS_SCAN2_HI  4'h3
`define OFS_MODE1_LO  4'h4
`define OFS_MODE1_HI  4'h5
`define OFS_MODE2_LO  4'h6
`define OFS_CTRL      4'h7
`define OFS_EFF_LO    4'h8
`define OFS_EFF_HI    4'h9
`define OFS_STATUS    4'ha

`define REG_RESET     16'h0000
`define PINS_RESET    32'h0000_0000
`define CTRL_EN1_BIT  0
`define CTRL_EN2_BIT  1
`define CTRL_W        2
// Status layout: channel 1 in [4:0], channel 2 in [11:8]
`define STS_CH1_LSB   0
`define STS_CH2_LSB   8
`define STS_ACT1_BIT  5
`define STS_ACT2_BIT  13
// Inputs bonded out on this part; value is arbitrary
`define PRESENT_MASK  32'h00ff_ffff

`endif

// [src/adc_scan_pkg.sv]
// Types shared by the scan-select and pin-mode block.
// Assumes the constants header is on the include path.
`include "adc_scan_params.svh"

package adc_scan_pkg;

  typedef enum logic {
    SCAN_IDLE,
    SCAN_RUN
  } scan_state_t;

  // What one converter's input multiplexer is told to do
  typedef struct packed {
    logic                  active;
    logic [`CHAN_W-1:0]    chan;
    logic                  low_ref;
    logic                  ground;
    logic                  wrap;
  } mux_sel_t;

endpackage

// [src/scan_walker.sv]
// Walks the selected inputs of one converter in ascending order.
// Assumes advance is a one-cycle pulse on the same clock.
`timescale 1ns/1ps
`default_nettype none

module scan_walker #(
  parameter int N  = 32,
  parameter int CW = 5
) (
  input  wire logic          mclk,
  input  wire logic          rst,
  input  wire logic          enable,
  input  wire logic          advance,
  input  wire logic [N-1:0]  mask,
  output logic      [CW-1:0] chan_q,
  output logic               active_q,
  output logic               wrap_q
);

  adc_scan_pkg::scan_state_t state_q, state_d;
  logic [CW-1:0] chan_d;
  logic          active_d;
  logic          wrap_d;

  function automatic logic [CW-1:0] first_set(input logic [N-1:0] m);
    logic [CW-1:0] r;
    r = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (m[i]) begin
        r = CW'(i);
      end
    end
    return r;
  endfunction

  // Next selected input above cur, wrapping past the top
  function automatic logic [CW-1:0] next_set(input logic [N-1:0] m,
                                             input logic [CW-1:0] cur);
    logic [CW-1:0] r;
    logic          found;
    int            idx;
    r = cur;
    found = 1'b0;
    idx = 0;
    for (int k = 1; k <= N; k++) begin
      idx = (int'(cur) + k) % N;
      if (!found && m[idx]) begin
        r = CW'(idx);
        found = 1'b1;
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_d  = state_q;
    chan_d   = chan_q;
    active_d = active_q;
    wrap_d   = 1'b0;
    case (state_q)
      adc_scan_pkg::SCAN_IDLE: begin
        if (enable && (|mask)) begin
          chan_d   = first_set(mask);
          active_d = 1'b1;
          state_d  = adc_scan_pkg::SCAN_RUN;
        end
      end
      adc_scan_pkg::SCAN_RUN: begin
        if (!enable || !(|mask)) begin
          active_d = 1'b0;
          state_d  = adc_scan_pkg::SCAN_IDLE;
        end else if (advance) begin
          chan_d = next_set(mask, chan_q);
          wrap_d = (next_set(mask, chan_q) <= chan_q);
        end
      end
      default: begin
        state_d  = adc_scan_pkg::SCAN_IDLE;
        active_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q  <= adc_scan_pkg::SCAN_IDLE;
      chan_q   <= '0;
      active_q <= 1'b0;
      wrap_q   <= 1'b0;
    end else begin
      state_q  <= state_d;
      chan_q   <= chan_d;
      active_q <= active_d;
      wrap_q   <= wrap_d;
    end
  end

endmodule

`default_nettype wire

// [test/adc_scan_and_pin_config_assertions.sv]
// Port checker of the scan-select and pin-mode block.
// Assumes the constants header is on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "adc_scan_params.svh"

module adc_scan_chk (
  input wire logic                   mclk,
  input wire logic                   rst,
  input wire logic [`ADDR_W-1:0]     addr,
  input wire logic [`DATA_W-1:0]     wdata,
  input wire logic                   wr,
  input wire logic                   rd,
  input wire logic [`DATA_W-1:0]     rdata_q,
  input wire logic                   conv1_done,
  input wire logic                   conv2_done,
  input wire adc_scan_pkg::mux_sel_t conv1_sel_q,
  input wire adc_scan_pkg::mux_sel_t conv2_sel_q,
  input wire logic [`NUM_INPUTS-1:0] pin_digital_q,
  input wire logic [`NUM_INPUTS-1:0] port_read_en_q
);
  localparam logic [31:0] PRES = `PRESENT_MASK;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  a_read_en_pins: assert property (
    port_read_en_q == pin_digital_q) else $error("read enable off mode");
  a_absent_ignored: assert property (
    (pin_digital_q & ~PRES) == '0) else $error("absent pin digital");
  a_rdata_idle: assert property (
    !$past(rd) |-> rdata_q == '0) else $error("read data without read");
  a_second_low: assert property (
    conv2_sel_q.chan[4] == 1'h0) else $error("second converter high input");
  a_wrap_active: assert property (
    conv1_sel_q.wrap |-> conv1_sel_q.active) else $error("wrap while idle");
  a_wrap_goes_down: assert property (
    conv1_sel_q.wrap |-> conv1_sel_q.chan <= $past(conv1_sel_q.chan))
    else $error("wrap did not return low");
  a_scan_ascends: assert property (
    conv1_sel_q.active && $past(conv1_sel_q.active) && !conv1_sel_q.wrap
    && conv1_sel_q.chan != $past(conv1_sel_q.chan)
    |-> conv1_sel_q.chan > $past(conv1_sel_q.chan))
    else $error("scan stepped downwards");
  a_chan_holds: assert property (
    $past(conv1_sel_q.active) && conv1_sel_q.active && !$past(conv1_done, 2)
    |-> $stable(conv1_sel_q.chan)) else $error("channel moved without done");
  a_absent_ref: assert property (
    conv1_sel_q.active |-> conv1_sel_q.low_ref == !PRES[conv1_sel_q.chan])
    else $error("reference flag wrong");
  a_reset_clears: assert property (
    $past(rst) |-> pin_digital_q == '0 && !conv1_sel_q.active
    && !conv2_sel_q.active) else $error("outputs not cleared by reset");

  c_wrap1: cover property (conv1_sel_q.wrap);
  c_scan2: cover property (conv2_sel_q.active);
  c_digital: cover property (pin_digital_q != '0);
endmodule

bind adc_scan_and_pin_config adc_scan_chk i_adc_scan_chk (
  .mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata_q(rdata_q), .conv1_done(conv1_done), .conv2_done(conv2_done),
  .conv1_sel_q(conv1_sel_q), .conv2_sel_q(conv2_sel_q),
  .pin_digital_q(pin_digital_q), .port_read_en_q(port_read_en_q));

`default_nettype wire

// [test/testbench.sv]
// Self-checking bench of the scan-select and pin-mode block.
// Assumes design, package and checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "adc_scan_params.svh"
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin \
  bad_count++; $display("[FAIL] %s exp %h got %h", n, e, s); end end

module testbench;
  logic                   mclk = 1'h0;
  logic                   rst = 1'h1;
  logic                   wr = 1'h0;
  logic                   rd = 1'h0;
  logic                   d1 = 1'h0;
  logic                   d2 = 1'h0;
  logic [3:0]             addr = 4'h0;
  logic [15:0]            wdata = 16'h0;
  logic [15:0]            rdata_q;
  logic [31:0]            pins;
  logic [31:0]            rden;
  logic [31:0]            eff;
  adc_scan_pkg::mux_sel_t s1;
  adc_scan_pkg::mux_sel_t s2;
  int                     bad_count = 0;
  int                     total_checks = 0;
  // Mode values chosen so each converter's own ground flag differs
  logic [15:0]            val [7] = '{16'h0012, 16'h8001, 16'h0009,
    16'hffff, 16'h00f0, 16'h7f0f, 16'h0f08};

  adc_scan_and_pin_config i_adc_scan_and_pin_config (
    .mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata_q(rdata_q), .conv1_done(d1), .conv2_done(d2),
    .conv1_sel_q(s1), .conv2_sel_q(s2), .pin_digital_q(pins),
    .port_read_en_q(rden));

  initial begin
    forever #5 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////
  function automatic adc_scan_pkg::mux_sel_t mk(input logic [4:0] c,
      input logic [2:0] f);
    mk = {1'h1, c, f};
  endfunction

  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge mclk);
    wr <= 1'h0;
  endtask

  task automatic rreg(input logic [3:0] a, input logic [15:0] e);
    @(posedge mclk);
    addr <= a;
    rd <= 1'h1;
    @(posedge mclk);
    rd <= 1'h0;
    #1;
    `CHK("rdata", e, rdata_q)
  endtask

  // Bounded wait, so a scan that never starts or never stops ends the run
  task automatic wait_on(input bit two, input logic want);
    int n;
    for (n = 0; n < 20 && (two ? s2.active : s1.active) !== want; n++)
      @(posedge mclk) #1;
    if (n == 20) begin
      bad_count++;
      summarize();
    end
  endtask

  task automatic step(input bit two, input adc_scan_pkg::mux_sel_t e);
    @(posedge mclk);
    if (two) d2 <= 1'h1;
    else d1 <= 1'h1;
    @(posedge mclk);
    d1 <= 1'h0;
    d2 <= 1'h0;
    @(posedge mclk);
    #1;
    `CHK("sel", e, two ? s2 : s1)
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    #1;
    `CHK("pins", 32'h0, pins)
    `CHK("sel1", 9'h0, s1)
    for (int i = 0; i < 11; i++)
      rreg(i[3:0], 16'h0000);
    $display("t_reset done");
  endtask

  task automatic t_regs;
    eff = {val[5], val[4] | val[6]} & `PRESENT_MASK;
    for (int i = 0; i < 7; i++)
      wreg(i[3:0], val[i]);
    for (int i = 0; i < 7; i++)
      rreg(i[3:0], val[i]);
    wreg(4'h8, 16'hffff);
    rreg(4'h8, eff[15:0]);
    rreg(4'h9, eff[31:16]);
    rreg(4'hb, 16'h0000);
    `CHK("pins", eff, pins)
    `CHK("rden", eff, rden)
    $display("t_regs done");
  endtask

  task automatic t_scan1;
    wreg(4'h7, 16'h0001);
    wait_on(1'h0, 1'h1);
    `CHK("sel1", mk(5'h01, 3'h0), s1)
    rreg(4'ha, 16'h0021);
    step(1'h0, mk(5'h04, 3'h2));
    step(1'h0, mk(5'h10, 3'h2));
    step(1'h0, mk(5'h1f, 3'h4));
    step(1'h0, mk(5'h01, 3'h1));
    wreg(4'h7, 16'h0000);
    wait_on(1'h0, 1'h0);
    $display("t_scan1 done");
  endtask

  task automatic t_scan2;
    wreg(4'h7, 16'h0002);
    wait_on(1'h1, 1'h1);
    `CHK("sel2", mk(5'h00, 3'h0), s2)
    step(1'h1, mk(5'h03, 3'h2));
    step(1'h1, mk(5'h00, 3'h1));
    $display("t_scan2 done");
  endtask

  task automatic t_rerst;
    @(posedge mclk);
    rst <= 1'h1;
    @(posedge mclk);
    rst <= 1'h0;
    #1;
    `CHK("pins", 32'h0, pins)
    `CHK("sel2", 9'h0, s2)
    rreg(4'h2, 16'h0000);
    $display("t_rerst done");
  endtask

  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'h0;
    t_reset();
    t_regs();
    t_scan1();
    t_scan2();
    t_rerst();
    summarize();
  end
endmodule

`default_nettype wire
